/* shared/cs_buf_pkg.sv */
// constants for the channel status double buffer
package cs_buf_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [7:0] ADDR_RX_DATA_CTRL = 8'h04;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h16;
  localparam logic [7:0] ADDR_CS_FIRST = 8'h23;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h48;
  // ==========================================
  // field positions
  localparam int COPY_INHIBIT_BIT = 0;
  localparam int ERR_GATE_BIT = 7;
  localparam int IRQ_COPY_BIT = 0;
  localparam int IRQ_SKIP_BIT = 1;
  localparam int OUT_SW_MODE_BIT = 0;
  localparam int OUT_PIN_SEL_LSB = 1;
  localparam int OUT_CLK_SEL_BIT = 3;
  // ==========================================
  // sizes and reset values
  localparam int CS_BYTES = 5;
  localparam int CS_BITS = 80;
  localparam int GPO_COUNT = 4;
  localparam int BLOCK_FRAMES = 192;
  localparam logic [7:0] RX_DATA_CTRL_RST = 8'h00;
  localparam logic [7:0] ERR_GATE_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [3:0] OUT_CTRL_RST = 4'h0;
endpackage

/* design/cs_edge_serial.sv */
// serial channel status output stepped on both frame clock edges
`timescale 1ns/10ps
module cs_edge_serial (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // frame clock, already synchronised
  input wire logic i_frame_clk,
  // serial bit from receiver and its output
  input wire logic i_cs_bit,
  output logic o_cs_ser
);
  logic frame_clk_q;
  logic cs_ser_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_clk_q <= 1'b0;
    end else begin
      frame_clk_q <= i_frame_clk;
    end
  end

  // one new bit per rising and per falling edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_ser_q <= 1'b0;
    end else if (frame_clk_q != i_frame_clk) begin
      cs_ser_q <= i_cs_bit;
    end
  end

  assign o_cs_ser = cs_ser_q;
endmodule

/* design/channel_status_buffer.sv */
// channel status capture and host buffers with apb access
//
// Functional notes
// - store five status bytes per channel
// - first arriving bit lands in byte msb
// - location 23h is channel A byte 0
// - capture buffer fills as bits arrive
// - host buffer takes whole blocks only
// - host buffer readable over control port
// - serial stream on pin or general output
// - serial output steps on both clock edges
// - gating off: only unlock or the inhibit bit blocks copy
// - gating on: any block error blocks copy
// - copy raises interrupt when enabled
// - inhibit bit at 04h stops copy
// - copies spaced one 192-frame block apart
// - gating bit in status register, reset 0
`timescale 1ns/10ps
module channel_status_buffer #(
  parameter int GPO_N = cs_buf_pkg::GPO_COUNT
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // receiver front end, same clock
  input wire logic I_CS_VALID,
  input wire logic I_CS_CHAN_B,
  input wire logic I_CS_BIT,
  input wire logic I_BLOCK_START,
  input wire logic I_PLL_UNLOCK,
  input wire logic I_BIPHASE_ERR,
  input wire logic I_CONF_ERR,
  input wire logic I_PARITY_ERR,
  input wire logic I_CRC_ERR,
  // frame clock pins
  input wire logic I_OUTPUT_FRAME_CLOCK,
  input wire logic I_ALTERNATE_FRAME_CLOCK,
  // serial outputs and interrupt
  output logic O_CS_SERIAL,
  output logic [GPO_N-1:0] O_GENERAL_OUTPUT_PIN,
  output logic O_IRQ
);
  localparam int NB = cs_buf_pkg::CS_BYTES;

  // ==========================================
  // registers
  logic [7:0] cap_a_q [NB];
  logic [7:0] cap_b_q [NB];
  logic [7:0] host_q [2*NB];
  logic [6:0] cnt_a_q;
  logic [6:0] cnt_b_q;
  logic blk_err_q;
  logic blk_unlock_q;
  logic seen_block_q;
  logic [7:0] rx_ctrl_q;
  logic err_gate_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [3:0] out_ctrl_q;
  logic [1:0] ofc_sync_q;
  logic [1:0] afc_sync_q;
  logic [31:0] prdata_q;
  logic copy_go;
  logic copy_skip;
  logic wr_en;
  logic rd_en;
  logic frame_clk;
  logic cs_ser;
  logic [31:0] rd_mux;
  logic [1:0] pin_sel;

  // ==========================================
  // apb decode
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;

  function automatic logic is_cs_addr(input logic [7:0] a);
    return (a >= cs_buf_pkg::ADDR_CS_FIRST) &&
           (a < cs_buf_pkg::ADDR_CS_FIRST + 8'(2*NB));
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return is_cs_addr(a) || a == cs_buf_pkg::ADDR_RX_DATA_CTRL ||
           a == cs_buf_pkg::ADDR_RX_STATUS || a == cs_buf_pkg::ADDR_IRQ_STATUS ||
           a == cs_buf_pkg::ADDR_IRQ_MASK || a == cs_buf_pkg::ADDR_OUT_CTRL;
  endfunction

  assign O_PSLVERR = I_PSEL && I_PENABLE && !is_mapped(I_PADDR);

  // ==========================================
  // block boundary decision
  // the copy happens at the start of the next block, closing the previous one
  always_comb begin
    copy_go = 1'b0;
    copy_skip = 1'b0;
    if (I_BLOCK_START && seen_block_q) begin
      if (blk_unlock_q || I_PLL_UNLOCK) begin
        copy_skip = 1'b1;
      end else if (err_gate_q && blk_err_q) begin
        copy_skip = 1'b1;
      end else if (rx_ctrl_q[cs_buf_pkg::COPY_INHIBIT_BIT]) begin
        copy_skip = 1'b1;
      end else begin
        copy_go = 1'b1;
      end
    end
  end

  // error tracking over one block
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      blk_err_q <= 1'b0;
      blk_unlock_q <= 1'b0;
      seen_block_q <= 1'b0;
    end else if (I_BLOCK_START) begin
      blk_err_q <= I_BIPHASE_ERR || I_CONF_ERR || I_PARITY_ERR || I_CRC_ERR;
      blk_unlock_q <= I_PLL_UNLOCK;
      seen_block_q <= 1'b1;
    end else begin
      blk_err_q <= blk_err_q || I_BIPHASE_ERR || I_CONF_ERR || I_PARITY_ERR || I_CRC_ERR;
      blk_unlock_q <= blk_unlock_q || I_PLL_UNLOCK;
    end
  end

  // ==========================================
  // capture buffer: bits counted per channel, first bit into msb
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_a_q <= 7'h00;
      cnt_b_q <= 7'h00;
    end else if (I_BLOCK_START) begin
      cnt_a_q <= 7'h00;
      cnt_b_q <= 7'h00;
    end else if (I_CS_VALID) begin
      if (!I_CS_CHAN_B && cnt_a_q < 7'(cs_buf_pkg::CS_BITS / 2)) begin
        cnt_a_q <= cnt_a_q + 7'h01;
      end
      if (I_CS_CHAN_B && cnt_b_q < 7'(cs_buf_pkg::CS_BITS / 2)) begin
        cnt_b_q <= cnt_b_q + 7'h01;
      end
    end
  end

  generate
    for (genvar g = 0; g < NB; g++) begin : g_cap
      always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          cap_a_q[g] <= 8'h00;
          cap_b_q[g] <= 8'h00;
        end else if (I_CS_VALID && !I_BLOCK_START) begin
          if (!I_CS_CHAN_B && cnt_a_q[6:3] == 4'(g)) begin
            cap_a_q[g][3'd7 - cnt_a_q[2:0]] <= I_CS_BIT;
          end
          if (I_CS_CHAN_B && cnt_b_q[6:3] == 4'(g)) begin
            cap_b_q[g][3'd7 - cnt_b_q[2:0]] <= I_CS_BIT;
          end
        end
      end

      // host buffer: channel A bytes first, channel B after
      always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          host_q[g] <= 8'h00;
          host_q[g+NB] <= 8'h00;
        end else if (copy_go) begin
          host_q[g] <= cap_a_q[g];
          host_q[g+NB] <= cap_b_q[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // control registers
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_ctrl_q <= cs_buf_pkg::RX_DATA_CTRL_RST;
      err_gate_q <= cs_buf_pkg::ERR_GATE_RST[0];
      irq_mask_q <= cs_buf_pkg::IRQ_MASK_RST;
      out_ctrl_q <= cs_buf_pkg::OUT_CTRL_RST;
    end else if (wr_en) begin
      if (I_PADDR == cs_buf_pkg::ADDR_RX_DATA_CTRL) begin
        rx_ctrl_q <= I_PWDATA[7:0];
      end
      if (I_PADDR == cs_buf_pkg::ADDR_RX_STATUS) begin
        err_gate_q <= I_PWDATA[cs_buf_pkg::ERR_GATE_BIT];
      end
      if (I_PADDR == cs_buf_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= I_PWDATA[1:0];
      end
      if (I_PADDR == cs_buf_pkg::ADDR_OUT_CTRL) begin
        out_ctrl_q <= I_PWDATA[3:0];
      end
    end
  end

  // sticky events, set beats write-one-to-clear
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q[cs_buf_pkg::IRQ_COPY_BIT] <= copy_go || (irq_stat_q[cs_buf_pkg::IRQ_COPY_BIT] &&
        !(wr_en && I_PADDR == cs_buf_pkg::ADDR_IRQ_STATUS && I_PWDATA[cs_buf_pkg::IRQ_COPY_BIT]));
      irq_stat_q[cs_buf_pkg::IRQ_SKIP_BIT] <= copy_skip || (irq_stat_q[cs_buf_pkg::IRQ_SKIP_BIT] &&
        !(wr_en && I_PADDR == cs_buf_pkg::ADDR_IRQ_STATUS && I_PWDATA[cs_buf_pkg::IRQ_SKIP_BIT]));
    end
  end

  assign O_IRQ = |(irq_stat_q & irq_mask_q);

  // ==========================================
  // read path
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_cs_addr(I_PADDR)) begin
      rd_mux[7:0] = host_q[4'(I_PADDR - cs_buf_pkg::ADDR_CS_FIRST)];
    end else begin
      unique case (I_PADDR)
        cs_buf_pkg::ADDR_RX_DATA_CTRL: rd_mux[7:0] = rx_ctrl_q;
        cs_buf_pkg::ADDR_RX_STATUS: rd_mux[7:0] = {err_gate_q, 3'h0, blk_err_q, 2'h0, blk_unlock_q};
        cs_buf_pkg::ADDR_IRQ_STATUS: rd_mux[1:0] = irq_stat_q;
        cs_buf_pkg::ADDR_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
        cs_buf_pkg::ADDR_OUT_CTRL: rd_mux[3:0] = out_ctrl_q;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prdata_q <= 32'h0000_0000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      prdata_q <= rd_mux;
    end
  end

  assign O_PRDATA = rd_en ? prdata_q : 32'h0000_0000;

  // ==========================================
  // serial output
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ofc_sync_q <= 2'h0;
      afc_sync_q <= 2'h0;
    end else begin
      ofc_sync_q <= {ofc_sync_q[0], I_OUTPUT_FRAME_CLOCK};
      afc_sync_q <= {afc_sync_q[0], I_ALTERNATE_FRAME_CLOCK};
    end
  end

  assign frame_clk = out_ctrl_q[cs_buf_pkg::OUT_CLK_SEL_BIT] ? afc_sync_q[1] : ofc_sync_q[1];
  assign pin_sel = out_ctrl_q[cs_buf_pkg::OUT_PIN_SEL_LSB +: 2];

  cs_edge_serial u_ser (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_frame_clk(frame_clk),
    .i_cs_bit(I_CS_BIT),
    .o_cs_ser(cs_ser)
  );

  // hardware mode uses the dedicated pin, software mode a chosen output
  always_comb begin
    O_GENERAL_OUTPUT_PIN = '0;
    O_CS_SERIAL = 1'b0;
    if (out_ctrl_q[cs_buf_pkg::OUT_SW_MODE_BIT]) begin
      O_GENERAL_OUTPUT_PIN[pin_sel] = cs_ser;
    end else begin
      O_CS_SERIAL = cs_ser;
    end
  end
endmodule

/* tb/csb_props.sv */
// port assertions for the channel status buffer
`timescale 1ns/10ps
module csb_props #(
  parameter int GPO_N = 4
) (
  input wire logic I_MCLK, I_RST_B, I_PSEL, I_PENABLE, I_PWRITE, I_BLOCK_START,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY, O_PSLVERR, O_CS_SERIAL, O_IRQ,
  input wire logic I_OUTPUT_FRAME_CLOCK, I_ALTERNATE_FRAME_CLOCK,
  input wire logic [GPO_N-1:0] O_GENERAL_OUTPUT_PIN
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  logic mapped, wr40, wr44, wr48, fc_chg;
  logic [1:0] fc_q;
  assign mapped = I_PADDR inside {8'h04, 8'h16, [8'h23:8'h2c], 8'h40, 8'h44, 8'h48};
  assign wr40 = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h40;
  assign wr44 = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h44;
  assign wr48 = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h48;
  assign fc_chg = fc_q != {I_OUTPUT_FRAME_CLOCK, I_ALTERNATE_FRAME_CLOCK};
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) fc_q <= 2'h0;
    else fc_q <= {I_OUTPUT_FRAME_CLOCK, I_ALTERNATE_FRAME_CLOCK};
  end
  sequence s_acc;
    I_PSEL && I_PENABLE;
  endsequence
  sequence s_edge_seen;
    $past(fc_chg, 2) || $past(fc_chg, 3) || $past(fc_chg, 4) || $past(wr48) || $past(wr48, 2);
  endsequence
  AST_PREADY: assert property (s_acc |-> O_PREADY) else $error("pready low in access");
  AST_PRDATA_IDLE: assert property (!(I_PSEL && I_PENABLE && !I_PWRITE) |-> O_PRDATA == 32'h0000_0000)
    else $error("read data outside read access");
  AST_SLVERR: assert property (s_acc |-> O_PSLVERR == !mapped) else $error("slave error wrong");
  AST_IRQ_RISE: assert property ($rose(O_IRQ) |-> $past(I_BLOCK_START) || $past(wr44))
    else $error("irq rose without boundary");
  AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> $past(wr40) || $past(wr44))
    else $error("irq fell without clear");
  AST_SER_EDGE: assert property ($changed(O_CS_SERIAL) |-> s_edge_seen)
    else $error("serial moved without frame edge");
  AST_SER_EXCL: assert property (O_CS_SERIAL |-> O_GENERAL_OUTPUT_PIN == '0)
    else $error("serial on both outputs");
  AST_GPO_ONE: assert property ($onehot0(O_GENERAL_OUTPUT_PIN)) else $error("several general outputs");
endmodule
bind channel_status_buffer csb_props #(.GPO_N(GPO_N)) csb_props_inst (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_BLOCK_START(I_BLOCK_START), .I_PADDR(I_PADDR),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CS_SERIAL(O_CS_SERIAL), .O_IRQ(O_IRQ),
  .I_OUTPUT_FRAME_CLOCK(I_OUTPUT_FRAME_CLOCK), .I_ALTERNATE_FRAME_CLOCK(I_ALTERNATE_FRAME_CLOCK),
  .O_GENERAL_OUTPUT_PIN(O_GENERAL_OUTPUT_PIN));

/* tb/rx_model.sv */
// receiver front end model sending channel status blocks
`timescale 1ns/10ps
module rx_model (
  input wire logic clk,
  output logic valid, chan_b, cbit, start,
  output logic [4:0] err
);
  initial begin
    {valid, chan_b, cbit, start, err} = '0;
  end
  task automatic boundary();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // 40 frames of a then b bits, closed by a boundary
  task automatic send_block(input logic [39:0] a, input logic [39:0] b, input logic [4:0] e);
    for (int k = 0; k < 80; k++) begin
      @(posedge clk);
      valid <= 1'b1;
      chan_b <= k[0];
      cbit <= k[0] ? b[39 - k / 2] : a[39 - k / 2];
      err <= (k == 20) ? e : 5'h00;
    end
    @(posedge clk);
    valid <= 1'b0;
    cbit <= ~cbit;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic set_bit(input logic v);
    @(posedge clk);
    cbit <= v;
  endtask
endmodule

/* tb/tb_channel_status_buffer.sv */
// self-checking bench for the channel status buffer
`timescale 1ns/10ps
module tb_channel_status_buffer;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, fo = 0, fa = 0, cp;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, cser, irq, valid, chb, cb, bs;
  logic [3:0] general_output_pin;
  logic [4:0] err;
  logic [31:0] exp_q[$];
  logic [39:0] a, b, na, nb;
  logic [7:0] regs[6] = '{8'h04, 8'h16, 8'h40, 8'h44, 8'h48, 8'h50};
  logic [4:0] ev[9] = '{5'h00, 5'h00, 5'h10, 5'h0f, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
  logic [11:0] st[6] = '{12'h060, 12'h000, 12'h8e0, 12'h820, 12'h544, 12'h748};
  int fail_count = 0, comparisons = 0, seed = 32'h32a0_2cfb;
  initial forever #12.5 clk = ~clk;
  channel_status_buffer channel_status_buffer_inst (.I_MCLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CS_VALID(valid), .I_CS_CHAN_B(chb), .I_CS_BIT(cb), .I_BLOCK_START(bs), .I_PLL_UNLOCK(err[4]),
    .I_BIPHASE_ERR(err[3]), .I_CONF_ERR(err[2]), .I_PARITY_ERR(err[1]), .I_CRC_ERR(err[0]),
    .I_OUTPUT_FRAME_CLOCK(fo), .I_ALTERNATE_FRAME_CLOCK(fa), .O_CS_SERIAL(cser), .O_GENERAL_OUTPUT_PIN(general_output_pin),
    .O_IRQ(irq));
  rx_model rx_model_inst (.clk(clk), .valid(valid), .chan_b(chb), .cbit(cb), .start(bs), .err(err));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("FAIL at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    {psel, pen} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, ad, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rd_buf(input logic [39:0] ea, input logic [39:0] eb);
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'h23 + i), 32'(ea[39 - 8 * i -: 8]));
      rd(8'(8'h28 + i), 32'(eb[39 - 8 * i -: 8]));
    end
  endtask
  task automatic fedge(input logic alt);
    @(posedge clk);
    if (alt) fa <= ~fa;
    else fo <= ~fo;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("counts: %0d compared, %0d failed", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) if (psel && pen && !pwr && pready) check(prdata, exp_q.pop_front());
  always @(posedge clk) if (psel && pen && pready) check(pslverr, paddr == 8'h50);
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0000_0000);
    $display("test reset values done");
    wr(8'h44, 32'h0000_0001);
    rx_model_inst.boundary();
    a = '0;
    b = '0;
    // plain, inhibited, unlocked, ungated errors, gated errors, clean
    for (int k = 0; k < 9; k++) begin
      cp = (k == 0 || k == 3 || k == 8);
      wr(8'h04, 32'(k == 1));
      wr(8'h16, 32'(k > 3) << 7);
      na = 40'({$random(seed), $random(seed)});
      nb = 40'({$random(seed), $random(seed)});
      rx_model_inst.send_block(na, nb, ev[k]);
      @(negedge clk);
      check(irq, cp);
      rd(8'h40, cp ? 32'h0000_0001 : 32'h0000_0002);
      rd(8'h16, 32'(k > 3) << 7);
      wr(8'h40, 32'h0000_0003);
      if (cp) begin
        a = na;
        b = nb;
      end
      rd_buf(a, b);
    end
    $display("test copy conditions done");
    wr(8'h44, 32'h0000_0000);
    rx_model_inst.send_block(a, b, 5'h00);
    @(negedge clk);
    check(irq, 0);
    wr(8'h44, 32'h0000_0001);
    @(negedge clk);
    check(irq, 1);
    wr(8'h40, 32'h0000_0003);
    @(negedge clk);
    check(irq, 0);
    $display("test interrupt mask done");
    foreach (st[i]) begin
      wr(8'h48, 32'(st[i][11:8]));
      rx_model_inst.set_bit(st[i][6]);
      fedge(st[i][7]);
      check(cser, st[i][5]);
      check(general_output_pin, st[i][3:0]);
    end
    $display("test serial output done");
    check(exp_q.size(), 0);
    print_verdict();
  end
endmodule
